/* File: shared/bit_branch_defs.svh */
// offsets, field positions, reset values and sizes of the bit/branch unit
`ifndef BIT_BRANCH_DEFS_SVH
`define BIT_BRANCH_DEFS_SVH

// apb register byte offsets
`define REG_CCR_OFF       12'h000
`define REG_PC_OFF        12'h004
`define REG_STATUS_OFF    12'h008
`define REG_STACK_OFF     12'h00C

// condition code register bit positions
`define CCR_C_POS         0
`define CCR_V_POS         1
`define CCR_Z_POS         2
`define CCR_N_POS         3
`define CCR_I_POS         7

// status register bit positions
`define STAT_BUSY_POS     0
`define STAT_TAKEN_POS    1
`define STAT_SP_LSB       4
`define STAT_SP_MSB       7

// reset values
`define CCR_RESET         8'h80
`define PC_RESET          24'h000000

// return stack size
`define RSTACK_DEPTH      8
`define RSTACK_IDX_W      3

`endif

/* File: shared/bit_branch_pkg.sv */
// types shared by the bit/branch unit and its bench
package bit_branch_pkg;

    typedef enum logic [3:0] {
        op_none                  = 4'h0,
        op_bit_or_carry          = 4'h1,
        op_inverted_bit_or_carry = 4'h2,
        op_bit_xor_carry         = 4'h3,
        op_inverted_bit_xor_carry = 4'h4,
        op_bit_load_carry        = 4'h5,
        op_inverted_bit_load_carry = 4'h6,
        op_carry_store_bit       = 4'h7,
        op_inverted_carry_store_bit = 4'h8,
        op_branch_cond           = 4'h9,
        op_jump_absolute         = 4'hA,
        op_relative_call         = 4'hB,
        op_absolute_call         = 4'hC,
        op_subroutine_return     = 4'hD
    } op_e;

    typedef enum logic [3:0] {
        branch_always         = 4'h0,
        branch_never          = 4'h1,
        branch_higher         = 4'h2,
        branch_lower_same     = 4'h3,
        branch_higher_same    = 4'h4,
        branch_carry_set      = 4'h5,
        branch_not_equal      = 4'h6,
        branch_equal          = 4'h7,
        branch_overflow_clear = 4'h8,
        branch_overflow_set   = 4'h9,
        branch_plus           = 4'hA,
        branch_minus          = 4'hB,
        branch_greater_equal  = 4'hC,
        branch_less_than      = 4'hD,
        branch_greater_than   = 4'hE,
        branch_less_equal     = 4'hF
    } cond_e;

    typedef enum logic [1:0] {
        mode_reg_direct   = 2'h0,
        mode_reg_indirect = 2'h1,
        mode_abs8         = 2'h2
    } mode_e;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_read  = 3'b010,
        st_write = 3'b100
    } state_e;

    typedef struct packed {
        logic        valid;
        op_e         op;
        logic [2:0]  bit_num;
        mode_e       mode;
        logic [23:0] ea;
        cond_e       cond;
        logic [23:0] target;
        logic [23:0] next_pc;
    } dec_req_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        mode_e       mode;
        logic [23:0] ea;
        logic [7:0]  wdata;
    } opnd_req_s;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } opnd_rsp_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        state_e            state;
        op_e               op;
        logic [2:0]        bit_num;
        logic [7:0]        condition_code_register;
        logic [23:0]       pc;
        logic              pc_valid;
        logic              done;
        logic              taken;
        logic [7:0][23:0]  rstack;
        logic [3:0]        sp;
        opnd_req_s         opnd;
    } unit_state_s;

endpackage

/* File: core/bit_carry_and_branch_condition_unit.sv */
// bit/carry operations and branch condition evaluation with apb access to ccr
`timescale 1ns/1ns
`include "bit_branch_defs.svh"

// Overview of operation
// RULE_01 - bit or carry: carry becomes carry OR selected operand bit
// RULE_02 - inverted bit or carry: carry becomes carry OR inverted operand bit
// RULE_03 - bit xor carry: carry becomes carry XOR selected operand bit
// RULE_04 - inverted bit xor carry: carry becomes carry XOR inverted operand bit
// RULE_05 - inverted carry operations take bit number only from 3-bit immediate
// RULE_06 - bit load carry: selected operand bit copied into carry
// RULE_07 - inverted bit load carry: complement of selected bit into carry
// RULE_08 - carry store bit: carry written into selected operand bit
// RULE_09 - inverted carry store bit: complement of carry into selected bit
// RULE_10 - conditional branch loads target only when its condition is true
// RULE_11 - always, never, zero, overflow and negative tests per flag value
// RULE_12 - unsigned tests: higher, lower-or-same, carry clear, carry set
// RULE_13 - signed tests built from N XOR V and Z
// RULE_14 - jump always loads the program counter with the target
// RULE_15 - both call forms save return point then go to subroutine
// RULE_16 - return resumes at point saved by most recent call; past 8 nested calls the code resumes at entry 7, the eighth call's point
// RULE_17 - store-bit operations read whole byte, change one bit, write back
// RULE_18 - operands by register direct, register indirect or 8-bit absolute
// RULE_19 - false condition continues sequentially with flags unchanged
// RULE_20 - carry operations change only the carry flag
module bit_carry_and_branch_condition_unit
    import bit_branch_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      srst,
    input  wire dec_req_s  dec_req,
    output logic           dec_ready,
    output logic           done,
    output logic           pc_load,
    output logic [23:0]    pc_target,
    output logic [7:0]     ccr_out,
    output opnd_req_s      opnd_req,
    input  wire opnd_rsp_s opnd_rsp,
    input  wire apb_req_s  apb_req,
    output apb_rsp_s       apb_rsp
);

    unit_state_s s;
    unit_state_s next_s;

    function automatic logic cond_true(input cond_e c, input logic [7:0] f);
        logic cf;
        logic vf;
        logic zf;
        logic nf;
        cf = f[`CCR_C_POS];
        vf = f[`CCR_V_POS];
        zf = f[`CCR_Z_POS];
        nf = f[`CCR_N_POS];
        case (c)
            branch_always:         cond_true = 1'b1;            // RULE_11
            branch_never:          cond_true = 1'b0;            // RULE_11
            branch_higher:         cond_true = !(cf | zf);      // RULE_12
            branch_lower_same:     cond_true = cf | zf;         // RULE_12
            branch_higher_same:    cond_true = !cf;             // RULE_12
            branch_carry_set:      cond_true = cf;              // RULE_12
            branch_not_equal:      cond_true = !zf;             // RULE_11
            branch_equal:          cond_true = zf;              // RULE_11
            branch_overflow_clear: cond_true = !vf;             // RULE_11
            branch_overflow_set:   cond_true = vf;              // RULE_11
            branch_plus:           cond_true = !nf;             // RULE_11
            branch_minus:          cond_true = nf;              // RULE_11
            branch_greater_equal:  cond_true = !(nf ^ vf);      // RULE_13
            branch_less_than:      cond_true = nf ^ vf;         // RULE_13
            branch_greater_than:   cond_true = !(zf | (nf ^ vf)); // RULE_13
            branch_less_equal:     cond_true = zf | (nf ^ vf);  // RULE_13
            default:               cond_true = 1'b0;
        endcase
    endfunction

    function automatic logic is_bit_op(input op_e o);
        is_bit_op = (o >= op_bit_or_carry) && (o <= op_inverted_carry_store_bit);
    endfunction

    // apb decode; zero wait states so pready is simply tied to the access phase
    logic        apb_wr;
    logic        apb_hit;
    logic [31:0] apb_rdata;

    always_comb begin
        apb_hit = 1'b1;
        apb_rdata = 32'h00000000;
        case (apb_req.paddr)
            `REG_CCR_OFF:    apb_rdata = {24'h000000, s.condition_code_register};
            `REG_PC_OFF:     apb_rdata = {8'h00, s.pc};
            `REG_STATUS_OFF: begin
                apb_rdata[`STAT_BUSY_POS] = (s.state != st_idle);
                apb_rdata[`STAT_TAKEN_POS] = s.taken;
                apb_rdata[`STAT_SP_MSB:`STAT_SP_LSB] = s.sp;
            end
            `REG_STACK_OFF:  apb_rdata = {8'h00, s.rstack[3'(s.sp - 4'h1)]};
            default:         apb_hit = 1'b0;
        endcase
    end

    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_hit;
    assign apb_rsp.pready = apb_req.psel && apb_req.penable;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !apb_hit;
    assign apb_rsp.prdata = (apb_req.psel && !apb_req.pwrite) ? apb_rdata : 32'h00000000;

    logic       opnd_bit;
    logic       new_c;
    logic [7:0] wbyte;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.pc_valid = 1'b0;
        opnd_bit = 1'b0;
        new_c = s.condition_code_register[`CCR_C_POS];
        wbyte = opnd_rsp.rdata;
        // software ccr write; an instruction updating carry in the same cycle wins
        if (apb_wr && apb_req.paddr == `REG_CCR_OFF) begin
            next_s.condition_code_register = apb_req.pwdata[7:0];
        end
        case (s.state)
            st_idle: begin
                if (dec_req.valid) begin
                    next_s.op = dec_req.op;
                    // bit position is always the 3-bit immediate; no register source
                    next_s.bit_num = dec_req.bit_num; // RULE_05
                    if (is_bit_op(dec_req.op)) begin
                        next_s.state = st_read;
                        next_s.opnd.rd = 1'b1;
                        next_s.opnd.wr = 1'b0;
                        next_s.opnd.mode = dec_req.mode; // RULE_18
                        next_s.opnd.ea = dec_req.ea;
                    end else begin
                        next_s.done = 1'b1;
                        case (dec_req.op)
                            op_branch_cond: begin
                                next_s.taken = cond_true(dec_req.cond, s.condition_code_register); // RULE_10
                                next_s.pc_valid = 1'b1;
                                // false condition: fall through, flags untouched
                                next_s.pc = next_s.taken ? dec_req.target
                                                         : dec_req.next_pc; // RULE_19
                            end
                            op_jump_absolute: begin
                                next_s.taken = 1'b1;
                                next_s.pc_valid = 1'b1;
                                next_s.pc = dec_req.target; // RULE_14
                            end
                            op_relative_call, op_absolute_call: begin
                                // a full stack holds sp at 8 and overwrites entry 0 on each further call
                                next_s.rstack[s.sp[2:0]] = dec_req.next_pc; // RULE_15
                                next_s.sp = (s.sp == 4'(`RSTACK_DEPTH)) ? s.sp
                                                                        : s.sp + 4'h1;
                                next_s.taken = 1'b1;
                                next_s.pc_valid = 1'b1;
                                next_s.pc = dec_req.target; // RULE_15
                            end
                            op_subroutine_return: begin
                                next_s.pc = s.rstack[3'(s.sp - 4'h1)]; // RULE_16
                                next_s.sp = (s.sp == 4'h0) ? s.sp : s.sp - 4'h1;
                                next_s.taken = 1'b1;
                                next_s.pc_valid = 1'b1;
                            end
                            default: begin
                                next_s.taken = 1'b0;
                            end
                        endcase
                    end
                end
            end
            st_read: begin
                if (opnd_rsp.ack) begin
                    opnd_bit = opnd_rsp.rdata[s.bit_num];
                    next_s.opnd.rd = 1'b0;
                    case (s.op)
                        op_bit_or_carry:            new_c = s.condition_code_register[`CCR_C_POS] | opnd_bit;  // RULE_01
                        op_inverted_bit_or_carry:   new_c = s.condition_code_register[`CCR_C_POS] | !opnd_bit; // RULE_02
                        op_bit_xor_carry:           new_c = s.condition_code_register[`CCR_C_POS] ^ opnd_bit;  // RULE_03
                        op_inverted_bit_xor_carry:  new_c = s.condition_code_register[`CCR_C_POS] ^ !opnd_bit; // RULE_04
                        op_bit_load_carry:          new_c = opnd_bit;                      // RULE_06
                        op_inverted_bit_load_carry: new_c = !opnd_bit;                     // RULE_07
                        op_carry_store_bit:
                            wbyte[s.bit_num] = s.condition_code_register[`CCR_C_POS];                          // RULE_08
                        op_inverted_carry_store_bit:
                            wbyte[s.bit_num] = !s.condition_code_register[`CCR_C_POS];                         // RULE_09
                        default: new_c = s.condition_code_register[`CCR_C_POS];
                    endcase
                    if (s.op == op_carry_store_bit || s.op == op_inverted_carry_store_bit) begin
                        // whole byte goes back so the other seven bits are preserved
                        next_s.state = st_write; // RULE_17
                        next_s.opnd.wr = 1'b1;
                        next_s.opnd.wdata = wbyte; // RULE_17
                    end else begin
                        next_s.state = st_idle;
                        next_s.done = 1'b1;
                        next_s.condition_code_register[`CCR_C_POS] = new_c; // RULE_20
                    end
                end
            end
            st_write: begin
                if (opnd_rsp.ack) begin
                    next_s.opnd.wr = 1'b0;
                    next_s.state = st_idle;
                    next_s.done = 1'b1;
                end
            end
            default: begin
                next_s.state = st_idle;
                next_s.opnd.rd = 1'b0;
                next_s.opnd.wr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
            s.state <= st_idle;
            s.condition_code_register <= `CCR_RESET;
            s.pc <= `PC_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign dec_ready = (s.state == st_idle);
    assign done = s.done;
    assign pc_load = s.pc_valid;
    assign pc_target = s.pc;
    assign ccr_out = s.condition_code_register;
    assign opnd_req = s.opnd;

endmodule

/* File: bench/bit_branch_asserts.sv */
// concurrent checks on the bit/carry and branch unit ports
`timescale 1ns/1ns
module bit_branch_checker
    import bit_branch_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire dec_req_s    dec_req,
    input wire logic        dec_ready,
    input wire logic        done,
    input wire logic        pc_load,
    input wire logic [23:0] pc_target,
    input wire logic [7:0]  ccr_out,
    input wire opnd_req_s   opnd_req,
    input wire opnd_rsp_s   opnd_rsp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [7:0]  rb, cp;
    logic [23:0] tg, nx;
    logic [15:0] fo, tv;
    logic [2:0]  bn;
    logic        n, z, v, c, s, inv;
    op_e         op;
    cond_e       cd;
    assign {n, z, v, c} = ccr_out[3:0];
    assign tv = {z | (n ^ v), ~(z | (n ^ v)), n ^ v, ~(n ^ v), n, ~n, v, ~v,
                 z, ~z, c, ~c, c | z, ~(c | z), 1'b0, 1'b1};
    assign fo = done ? 16'h0001 << op : 16'h0000;
    assign s = rb[bn];
    assign inv = op == op_inverted_carry_store_bit;
    // operand byte and flags are caught at the read answer, before any update
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            op <= op_none;
        end else if (dec_req.valid && dec_ready) begin
            op <= dec_req.op;
            bn <= dec_req.bit_num;
            cd <= dec_req.cond;
            tg <= dec_req.target;
            nx <= dec_req.next_pc;
        end
        if (opnd_rsp.ack && opnd_req.rd) begin
            rb <= opnd_rsp.rdata;
            cp <= ccr_out;
        end
    end
    property p_or; fo[op_bit_or_carry] |-> c == (cp[0] | s); endproperty
    a_or: assert property (p_or) else $error("or carry wrong");
    property p_ior; fo[op_inverted_bit_or_carry] |-> c == (cp[0] | !s); endproperty
    a_ior: assert property (p_ior) else $error("inverted or wrong");
    property p_xor; fo[op_bit_xor_carry] |-> c == (cp[0] ^ s); endproperty
    a_xor: assert property (p_xor) else $error("xor carry wrong");
    property p_ixor; fo[op_inverted_bit_xor_carry] |-> c == (cp[0] ^ !s); endproperty
    a_ixor: assert property (p_ixor) else $error("inverted xor wrong");
    property p_ld; fo[op_bit_load_carry] |-> c == s; endproperty
    a_ld: assert property (p_ld) else $error("load carry wrong");
    property p_ild; fo[op_inverted_bit_load_carry] |-> c == !s; endproperty
    a_ild: assert property (p_ild) else $error("inverted load wrong");
    property p_keep; (|fo[6:1]) |-> ccr_out[7:1] == cp[7:1]; endproperty
    a_keep: assert property (p_keep) else $error("other flags moved");
    property p_st;
        $rose(opnd_req.wr) |-> !opnd_req.rd && (opnd_req.wdata ^ rb) == ({7'h00, cp[0] ^ s ^ inv} << bn);
    endproperty
    a_st: assert property (p_st) else $error("stored byte wrong");
    property p_br; fo[op_branch_cond] |-> pc_load && pc_target == (tv[cd] ? tg : nx); endproperty
    a_br: assert property (p_br) else $error("branch target wrong");
    property p_fl; fo[op_branch_cond] |-> $stable(ccr_out); endproperty
    a_fl: assert property (p_fl) else $error("branch moved flags");
    property p_jump;
        fo[op_jump_absolute] || fo[op_absolute_call] || fo[op_relative_call]
            |-> pc_load && pc_target == tg;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_lat; dec_req.valid && dec_ready && dec_req.op >= op_branch_cond |=> done && pc_load; endproperty
    a_lat: assert property (p_lat) else $error("branch not finished");
    c_taken: cover property (fo[op_branch_cond] && tv[cd]);
    c_store: cover property ($rose(opnd_req.wr));
    c_ret: cover property (fo[op_subroutine_return]);
endmodule

bind bit_carry_and_branch_condition_unit bit_branch_checker u_chk (
    .ref_clk(ref_clk), .srst(srst), .dec_req(dec_req), .dec_ready(dec_ready),
    .done(done), .pc_load(pc_load), .pc_target(pc_target), .ccr_out(ccr_out),
    .opnd_req(opnd_req), .opnd_rsp(opnd_rsp)
);

/* File: bench/opnd_path_model.sv */
// stand-in for the register file and memory operand path
`timescale 1ns/1ns
module opnd_path_model
    import bit_branch_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic [3:0] dly,
    input  wire opnd_req_s  opnd_req,
    output opnd_rsp_s       opnd_rsp
);
    logic [7:0] mem [0:255];
    logic [7:0] idx;
    logic [3:0] cnt;
    // each mode has its own space, so a wrong mode fetches a wrong byte
    assign idx = {opnd_req.mode, opnd_req.ea[5:0]};
    // data churns between answers so a late sample never looks valid
    always @(posedge ref_clk) begin
        opnd_rsp.rdata <= ~opnd_rsp.rdata;
        if (srst || opnd_rsp.ack || !(opnd_req.rd || opnd_req.wr)) begin
            opnd_rsp.ack <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt < dly) begin
            cnt <= cnt + 4'h1;
        end else begin
            opnd_rsp.ack <= 1'b1;
            opnd_rsp.rdata <= mem[idx];
            if (opnd_req.wr) begin
                mem[idx] <= opnd_req.wdata;
            end
        end
    end
endmodule

/* File: bench/bit_carry_and_branch_condition_unit_tb_top.sv */
// bench for the bit/carry and branch unit
`timescale 1ns/1ns
module bit_carry_and_branch_condition_unit_tb_top
    import bit_branch_pkg::*;
;
    logic        ref_clk, srst, dec_ready, done, pc_load, pl, cv, sb, ec, e, n, z, v, c;
    logic [23:0] pc_target, tg, nx;
    logic [31:0] q;
    logic [15:0] tv;
    logic [7:0]  ccr_out, dv, eb, pre;
    logic [3:0]  dly, f;
    logic [2:0]  b;
    dec_req_s    dec_req;
    opnd_req_s   opnd_req;
    opnd_rsp_s   opnd_rsp;
    apb_req_s    apb_req;
    apb_rsp_s    apb_rsp;
    op_e         o;
    mode_e       m;
    int          bad_count, n_tests;
    int          cyc = 0;
    bit_carry_and_branch_condition_unit u_dut (
        .ref_clk(ref_clk), .srst(srst), .dec_req(dec_req), .dec_ready(dec_ready),
        .done(done), .pc_load(pc_load), .pc_target(pc_target), .ccr_out(ccr_out),
        .opnd_req(opnd_req), .opnd_rsp(opnd_rsp), .apb_req(apb_req), .apb_rsp(apb_rsp));
    opnd_path_model u_opnd (
        .ref_clk(ref_clk), .srst(srst), .dly(dly), .opnd_req(opnd_req), .opnd_rsp(opnd_rsp));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        // an idle edge keeps the next setup out of this release step
        apb_req <= '0;
        @(posedge ref_clk);
    endtask
    // valid is held until an edge sees dec_ready high
    task automatic run(input op_e op, input cond_e cc);
        dec_req <= '{1'b1, op, b, m, {21'h0, b}, cc, tg, nx};
        do begin
            @(posedge ref_clk);
        end while (dec_ready !== 1'b1);
        dec_req.valid <= 1'b0;
        do begin
            @(posedge ref_clk);
        end while (done !== 1'b1);
        pl = pc_load;
        chk({23'h0, done}, 24'h000001);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        srst = 1'b1;
        dly = 4'h0;
        b = 3'h0;
        m = mode_reg_direct;
        tg = 24'h0;
        nx = 24'h0;
        dec_req = '0;
        apb_req = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk({16'h0, ccr_out}, 24'h80);
        chk(pc_target, 24'h000000);
        chk({21'h0, dec_ready, done, pc_load}, 24'h000004);
        $display("test reset done");
        // every bit op, both carries, three modes, slow and prompt answers
        for (int i = 0; i < 48; i++) begin
            o = op_e'(1 + i % 8);
            m = mode_e'(i / 16);
            b = 3'(i * 5);
            cv = i[3];
            dv = 8'(i * 37) ^ 8'h5A;
            dly = 4'(i % 4);
            pre = {7'h45, cv};
            apb(1'b1, 12'h000, {24'h0, pre});
            u_opnd.mem[{m, 3'h0, b}] = dv;
            run(o, branch_always);
            sb = dv[b];
            case (o)
                op_bit_or_carry: ec = cv | sb;
                op_inverted_bit_or_carry: ec = cv | ~sb;
                op_bit_xor_carry: ec = cv ^ sb;
                op_inverted_bit_xor_carry: ec = cv ^ ~sb;
                op_bit_load_carry: ec = sb;
                op_inverted_bit_load_carry: ec = ~sb;
                default: ec = cv;
            endcase
            eb = dv;
            eb[b] = cv ^ (o == op_inverted_carry_store_bit);
            chk({16'h0, ccr_out}, {16'h0, pre[7:1], ec});
            if (o >= op_carry_store_bit) begin
                chk({16'h0, u_opnd.mem[{m, 3'h0, b}]}, {16'h0, eb});
            end
        end
        $display("test bit ops done");
        for (int i = 0; i < 256; i++) begin
            f = 4'(i);
            {n, z, v, c} = f;
            tv = {z | (n ^ v), ~(z | (n ^ v)), n ^ v, ~(n ^ v), n, ~n, v, ~v,
                  z, ~z, c, ~c, c | z, ~(c | z), 1'b0, 1'b1};
            tg = 24'h123400 ^ 24'(i);
            nx = 24'h000200 + 24'(i);
            apb(1'b1, 12'h000, {28'h0000008, f});
            run(op_branch_cond, cond_e'(i / 16));
            chk(pc_target, tv[i / 16] ? tg : nx);
            chk({16'h0, ccr_out}, {20'h00008, f});
            chk({23'h0, pl}, 24'h000001);
        end
        $display("test branches done");
        tg = 24'hABCDEF;
        run(op_jump_absolute, branch_never);
        chk(pc_target, 24'hABCDEF);
        for (int j = 0; j < 2; j++) begin
            tg = 24'h010000 << j;
            nx = 24'h000100 + 24'(j);
            run(j ? op_relative_call : op_absolute_call, branch_never);
            chk(pc_target, tg);
        end
        for (int j = 1; j >= 0; j--) begin
            tg = 24'hFFFFFF;
            run(op_subroutine_return, branch_never);
            chk(pc_target, 24'h000100 + 24'(j));
        end
        apb(1'b0, 12'h000, 32'h0);
        chk(q[23:0], 24'h00008F);
        apb(1'b0, 12'h010, 32'h0);
        chk({23'h0, e}, 24'h000001);
        apb(1'b0, 12'h004, 32'h0);
        chk(q[23:0], 24'h000100);
        apb(1'b0, 12'h008, 32'h0);
        chk(q[23:0], 24'h000002);
        $display("test jumps and bus done");
        end_sim();
    end
endmodule
